// file: ccu_defines.svh
// register offsets, field positions, reset values and counts for the capture/compare unit
// assumes a 32-bit AHB-Lite slave decoding byte offsets in haddr[7:0]
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// ============================================================
// register byte offsets
`define CCU_OFF_CTRL      8'h00
`define CCU_OFF_VAL_LO    8'h04
`define CCU_OFF_VAL_HI    8'h08
`define CCU_OFF_TB_CTRL   8'h0C
`define CCU_OFF_TB_CNT    8'h10
`define CCU_OFF_TA_CNT    8'h14
`define CCU_OFF_STATUS    8'h18
`define CCU_OFF_MISC      8'h1C

// ============================================================
// field positions
`define CCU_TB_SRC_HI     6
`define CCU_TB_SRC_LO     3
`define CCU_TB_ON         0
`define CCU_ST_EVENT      0
`define CCU_ST_TB_OVF     1
`define CCU_MISC_CAN_SEL  0
`define CCU_MISC_DIR_IN   1
`define CCU_MISC_LATCH    2
`define CCU_MISC_ADC_EN   3
`define CCU_MISC_TA_ON    4

// ============================================================
// reset values and counts
`define CCU_RST_BYTE      8'h00
`define CCU_RST_CNT       16'h0000
`define CCU_CNT_MAX       16'hFFFF
`define CCU_PRE_4TH       4'h3
`define CCU_PRE_16TH      4'hF

`endif

// file: ccu_pkg.sv
// types and shared mode decoding of the capture/compare unit
// numbers its own mode codes; needs nothing from ccu_defines.svh
package ccu_pkg;

  typedef logic [31:0] ccu_word_t;

  typedef enum logic [3:0] {
    CCU_OFF        = 4'h0,
    CCU_RESERVED   = 4'h1,
    CCU_CMP_TOGGLE = 4'h2,
    CCU_CAP_CAN    = 4'h3,
    CCU_CAP_FALL   = 4'h4,
    CCU_CAP_RISE   = 4'h5,
    CCU_CAP_RISE4  = 4'h6,
    CCU_CAP_RISE16 = 4'h7,
    CCU_CMP_SET    = 4'h8,
    CCU_CMP_CLR    = 4'h9,
    CCU_CMP_SOFT   = 4'hA,
    CCU_CMP_TRIG   = 4'hB,
    CCU_PWM0       = 4'hC,
    CCU_PWM1       = 4'hD,
    CCU_PWM2       = 4'hE,
    CCU_PWM3       = 4'hF
  } ccu_mode_t;

  function automatic logic ccu_is_capture(input ccu_mode_t m);
    ccu_is_capture = (m >= CCU_CAP_CAN) && (m <= CCU_CAP_RISE16);
  endfunction

  function automatic logic ccu_is_compare(input ccu_mode_t m);
    ccu_is_compare = (m == CCU_CMP_TOGGLE) || ((m >= CCU_CMP_SET) && (m <= CCU_CMP_TRIG));
  endfunction

endpackage

// file: ccu_capture_trigger.sv
// capture event source: pin synchroniser, edge select, prescaler, can event
// assumes the pin is asynchronous and the can receive level is on hclk
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

module ccu_capture_trigger (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              pin_raw,
  input  wire logic              pin_is_output,
  input  wire logic              pin_driven,
  input  wire logic              can_select,
  input  wire logic              can_rx_event,
  input  wire ccu_pkg::ccu_mode_t mode,
  output logic                   capture_event
);
  import ccu_pkg::*;

  // ============================================================
  // pin synchroniser, level accepted once stages two and three agree
  logic sync1_q, sync2_q, sync3_q, pin_lvl_q, eff_prev_q, can_prev_q;
  logic [3:0] pre_cnt_q;
  logic [3:0] pre_cnt_d;
  logic       rise, fall, can_rise, eff_lvl, pre_hit, cap_d;

  // a driven pin is seen at its own drive level, so port writes can capture
  assign eff_lvl  = pin_is_output ? pin_driven : pin_lvl_q;
  assign rise     = eff_lvl & ~eff_prev_q;
  assign fall     = ~eff_lvl & eff_prev_q;
  assign can_rise = can_rx_event & ~can_prev_q;

  // ============================================================
  // prescaler
  assign pre_hit = ((mode == CCU_CAP_RISE4) && (pre_cnt_q == `CCU_PRE_4TH)) ||
                   ((mode == CCU_CAP_RISE16) && (pre_cnt_q == `CCU_PRE_16TH));

  // cleared outside capture and after each prescaled event; switching prescalers keeps the count
  assign pre_cnt_d = !ccu_is_capture(mode) ? 4'h0 :
                     (rise && pre_hit)     ? 4'h0 :
                     (rise && (mode == CCU_CAP_RISE4 || mode == CCU_CAP_RISE16)) ?
                     pre_cnt_q + 4'h1 : pre_cnt_q;

  // can select blocks pin events; only CCU_CAP_CAN mode captures on the can receive edge
  assign cap_d = (can_select || mode == CCU_CAP_CAN) ? (mode == CCU_CAP_CAN && can_rise) :
                 (mode == CCU_CAP_FALL)   ? fall :
                 (mode == CCU_CAP_RISE)   ? rise :
                 (mode == CCU_CAP_RISE4 || mode == CCU_CAP_RISE16) ? (rise && pre_hit) : 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q       <= 1'b0;
      sync2_q       <= 1'b0;
      sync3_q       <= 1'b0;
      pin_lvl_q     <= 1'b0;
      eff_prev_q    <= 1'b0;
      can_prev_q    <= 1'b0;
      pre_cnt_q     <= 4'h0;
      capture_event <= 1'b0;
    end
    else
    begin
      sync1_q       <= pin_raw;
      sync2_q       <= sync1_q;
      sync3_q       <= sync2_q;
      pin_lvl_q     <= (sync2_q == sync3_q) ? sync3_q : pin_lvl_q;
      eff_prev_q    <= eff_lvl;
      can_prev_q    <= can_rx_event;
      pre_cnt_q     <= pre_cnt_d;
      capture_event <= cap_d;
    end
  end

endmodule // ccu_capture_trigger
`default_nettype wire

// file: ccu_capture_unit.sv
// capture/compare unit with its two 16-bit timers and an AHB-Lite register slave
// assumes one AHB-Lite master, word accesses only, zero-wait answers
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

module ccu_capture_unit (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire ccu_pkg::ccu_word_t haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire ccu_pkg::ccu_word_t hwdata,
  input  wire logic              hready,
  output ccu_pkg::ccu_word_t     hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              capture_pin_in,
  input  wire logic              can_rx_event,
  output logic                   capture_pin_out,
  output logic                   capture_pin_oe_n,
  output logic                   adc_start,
  output logic                   unit_event_flag,
  output logic                   timer_b_overflow_flag
);
  import ccu_pkg::*;

  // ============================================================
  // state
  ccu_mode_t   unit_mode_select_q;
  logic [1:0]  duty_low_bits_q;
  logic [7:0]  value_low_byte_q;
  logic [7:0]  value_high_byte_q;
  logic [7:0]  timer_b_control_q;
  logic [15:0] timer_b_count_q;
  logic [15:0] timer_a_count_q;
  logic        can_select_q;
  logic        dir_in_q;
  logic        port_latch_q;
  logic        adc_enable_q;
  logic        timer_a_on_q;
  logic        cmp_out_q;
  logic        match_prev_q;
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        cap_ev;

  // ============================================================
  // bus decode
  logic        addr_phase;
  logic        wr_ctrl, wr_lo, wr_hi, wr_tbc, wr_tb, wr_ta, wr_st, wr_misc;
  ccu_word_t   rd_mux;
  logic [7:0]  ra;

  assign addr_phase = hsel && htrans[1] && hready;
  assign ra         = haddr[7:0];
  assign wr_ctrl    = wr_pend_q && (addr_q == `CCU_OFF_CTRL);
  assign wr_lo      = wr_pend_q && (addr_q == `CCU_OFF_VAL_LO);
  assign wr_hi      = wr_pend_q && (addr_q == `CCU_OFF_VAL_HI);
  assign wr_tbc     = wr_pend_q && (addr_q == `CCU_OFF_TB_CTRL);
  assign wr_tb      = wr_pend_q && (addr_q == `CCU_OFF_TB_CNT);
  assign wr_ta      = wr_pend_q && (addr_q == `CCU_OFF_TA_CNT);
  assign wr_st      = wr_pend_q && (addr_q == `CCU_OFF_STATUS);
  assign wr_misc    = wr_pend_q && (addr_q == `CCU_OFF_MISC);

  // unmapped offsets read zero and still answer okay
  assign rd_mux =
    (ra == `CCU_OFF_CTRL)    ? {24'h000000, 2'b00, duty_low_bits_q, unit_mode_select_q} :
    (ra == `CCU_OFF_VAL_LO)  ? {24'h000000, value_low_byte_q} :
    (ra == `CCU_OFF_VAL_HI)  ? {24'h000000, value_high_byte_q} :
    (ra == `CCU_OFF_TB_CTRL) ? {24'h000000, timer_b_control_q} :
    (ra == `CCU_OFF_TB_CNT)  ? {16'h0000, timer_b_count_q} :
    (ra == `CCU_OFF_TA_CNT)  ? {16'h0000, timer_a_count_q} :
    (ra == `CCU_OFF_STATUS)  ? {30'h00000000, timer_b_overflow_flag, unit_event_flag} :
    (ra == `CCU_OFF_MISC)    ? {27'h0000000, timer_a_on_q, adc_enable_q, port_latch_q,
                                dir_in_q, can_select_q} :
    32'h00000000;

  // ============================================================
  // timer selection and compare
  logic        src_timer_b;
  logic [15:0] sel_count;
  logic        is_cap, is_cmp, match, cmp_ev, trig_ev;
  logic [15:0] tb_next, ta_next;
  logic        tb_on, tb_ovf, st_ev, st_ovf;

  assign src_timer_b = timer_b_control_q[`CCU_TB_SRC_HI];
  assign sel_count   = src_timer_b ? timer_b_count_q : timer_a_count_q;
  assign is_cap      = ccu_is_capture(unit_mode_select_q);
  assign is_cmp      = ccu_is_compare(unit_mode_select_q);
  assign match       = is_cmp && ({value_high_byte_q, value_low_byte_q} == sel_count);
  // one event per match entry; the timer may sit on the value for several cycles
  assign cmp_ev      = match && !match_prev_q;
  assign trig_ev     = cmp_ev && (unit_mode_select_q == CCU_CMP_TRIG);
  assign tb_on       = timer_b_control_q[`CCU_TB_ON];

  // in trigger mode the period is the value pair plus one: each match restarts the selected timer at zero
  assign tb_next = wr_tb                  ? hwdata[15:0] :
                   (trig_ev && src_timer_b) ? `CCU_RST_CNT :
                   tb_on                  ? timer_b_count_q + 16'h0001 :
                   timer_b_count_q;
  assign ta_next = wr_ta                    ? hwdata[15:0] :
                   (trig_ev && !src_timer_b) ? `CCU_RST_CNT :
                   timer_a_on_q             ? timer_a_count_q + 16'h0001 :
                   timer_a_count_q;

  // overflow only from counting, never from the trigger clear or a write
  assign tb_ovf = tb_on && !wr_tb && !(trig_ev && src_timer_b) &&
                  (timer_b_count_q == `CCU_CNT_MAX);

  // set wins over a software clear in the same cycle
  assign st_ev  = (cap_ev && is_cap) || cmp_ev ||
                  (unit_event_flag && !(wr_st && hwdata[`CCU_ST_EVENT]));
  assign st_ovf = tb_ovf ||
                  (timer_b_overflow_flag && !(wr_st && hwdata[`CCU_ST_TB_OVF]));

  // ============================================================
  // capture trigger source
  ccu_capture_trigger u_trigger (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .pin_raw       (capture_pin_in),
    .pin_is_output (!dir_in_q),
    .pin_driven    (capture_pin_out),
    .can_select    (can_select_q),
    .can_rx_event  (can_rx_event),
    .mode          (unit_mode_select_q),
    .capture_event (cap_ev)
  );

  // ============================================================
  // compare output latch
  ccu_mode_t new_mode;
  logic      cmp_out_d;
  logic      pin_d;

  assign new_mode  = ccu_mode_t'(hwdata[3:0]);
  assign cmp_out_d =
    (wr_ctrl && new_mode == CCU_CMP_CLR)                  ? 1'b1 :
    (wr_ctrl)                                             ? 1'b0 :
    (unit_mode_select_q == CCU_OFF)                       ? 1'b0 :
    (cmp_ev && unit_mode_select_q == CCU_CMP_TOGGLE)      ? !cmp_out_q :
    (cmp_ev && unit_mode_select_q == CCU_CMP_SET)         ? 1'b1 :
    (cmp_ev && unit_mode_select_q == CCU_CMP_CLR)         ? 1'b0 :
    cmp_out_q;

  // soft and trigger compare leave the pin to the port latch
  assign pin_d = (unit_mode_select_q == CCU_CMP_TOGGLE ||
                  unit_mode_select_q == CCU_CMP_SET ||
                  unit_mode_select_q == CCU_CMP_CLR) ? cmp_out_q : port_latch_q;

  // ============================================================
  // bus slave flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      addr_q    <= addr_phase ? ra : addr_q;
      hrdata    <= (addr_phase && !hwrite) ? rd_mux : hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ============================================================
  // control and configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unit_mode_select_q <= CCU_OFF;
      duty_low_bits_q    <= 2'b00;
      timer_b_control_q  <= `CCU_RST_BYTE;
      can_select_q       <= 1'b0;
      dir_in_q           <= 1'b1;
      port_latch_q       <= 1'b0;
      adc_enable_q       <= 1'b0;
      timer_a_on_q       <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        unit_mode_select_q <= new_mode;
        duty_low_bits_q    <= hwdata[5:4];
      end
      if (wr_tbc)
      begin
        timer_b_control_q <= hwdata[7:0];
      end
      if (wr_misc)
      begin
        can_select_q <= hwdata[`CCU_MISC_CAN_SEL];
        dir_in_q     <= hwdata[`CCU_MISC_DIR_IN];
        port_latch_q <= hwdata[`CCU_MISC_LATCH];
        adc_enable_q <= hwdata[`CCU_MISC_ADC_EN];
        timer_a_on_q <= hwdata[`CCU_MISC_TA_ON];
      end
    end
  end

  // ============================================================
  // value pair, timers, flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      value_low_byte_q  <= `CCU_RST_BYTE;
      value_high_byte_q <= `CCU_RST_BYTE;
      timer_b_count_q   <= `CCU_RST_CNT;
      timer_a_count_q   <= `CCU_RST_CNT;
      unit_event_flag   <= 1'b0;
      timer_b_overflow_flag <= 1'b0;
    end
    else
    begin
      // a capture overwrites an unread value and beats a software write
      if (cap_ev && is_cap)
      begin
        value_low_byte_q  <= sel_count[7:0];
        value_high_byte_q <= sel_count[15:8];
      end
      else
      begin
        value_low_byte_q  <= wr_lo ? hwdata[7:0] : value_low_byte_q;
        value_high_byte_q <= wr_hi ? hwdata[7:0] : value_high_byte_q;
      end
      timer_b_count_q       <= tb_next;
      timer_a_count_q       <= ta_next;
      unit_event_flag       <= st_ev;
      timer_b_overflow_flag <= st_ovf;
    end
  end

  // ============================================================
  // pin and conversion start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_out_q        <= 1'b0;
      match_prev_q     <= 1'b0;
      capture_pin_out  <= 1'b0;
      capture_pin_oe_n <= 1'b1;
      adc_start        <= 1'b0;
    end
    else
    begin
      cmp_out_q        <= cmp_out_d;
      match_prev_q     <= match;
      capture_pin_out  <= pin_d;
      capture_pin_oe_n <= dir_in_q;
      adc_start        <= trig_ev && adc_enable_q;
    end
  end

endmodule // ccu_capture_unit
`default_nettype wire

// file: ccu_capture_unit_checker.sv
// port checker of the capture/compare unit
// assumes zero-wait bus answers and byte offsets in haddr[7:0]
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

module ccu_capture_unit_checker (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire ccu_pkg::ccu_word_t haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire ccu_pkg::ccu_word_t hwdata,
  input wire logic               hready,
  input wire ccu_pkg::ccu_word_t hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               capture_pin_in,
  input wire logic               can_rx_event,
  input wire logic               capture_pin_out,
  input wire logic               capture_pin_oe_n,
  input wire logic               adc_start,
  input wire logic               unit_event_flag,
  input wire logic               timer_b_overflow_flag
);
  import ccu_pkg::*;
  // ============================================================
  // data phase tracking, mirrors what the slave has taken
  logic       wr_q;
  logic       rd_q;
  logic [7:0] off_q;
  logic [3:0] mode_q;
  wire        take_w  = hsel && htrans[1] && hready;
  wire        wr_ctrl = wr_q && (off_q == `CCU_OFF_CTRL);
  wire        wr_st   = wr_q && (off_q == `CCU_OFF_STATUS);
  wire        wr_misc = wr_q && (off_q == `CCU_OFF_MISC);
  wire        rd_ctrl = rd_q && (off_q == `CCU_OFF_CTRL);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      off_q  <= 8'h00;
      mode_q <= 4'h0;
    end
    else
    begin
      wr_q   <= take_w && hwrite;
      rd_q   <= take_w && !hwrite;
      off_q  <= take_w ? haddr[7:0] : off_q;
      mode_q <= wr_ctrl ? hwdata[3:0] : mode_q;
    end
  end
  // ============================================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  pulse_once_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start lasted more than one cycle");
  trig_event_a: assert property (adc_start |-> unit_event_flag && mode_q == 4'hB)
    else $error("conversion start without event flag in trigger mode");
  event_sticky_a: assert property ($fell(unit_event_flag) |-> $past(wr_st && hwdata[0]))
    else $error("event flag dropped without a clearing write");
  ovf_sticky_a: assert property ($fell(timer_b_overflow_flag) |-> $past(wr_st && hwdata[1]))
    else $error("overflow flag dropped without a clearing write");
  ctrl_top_a: assert property (rd_ctrl |-> hrdata[7:6] == 2'b00)
    else $error("control bits 7 and 6 read nonzero");
  pin_dir_a: assert property ($past(wr_misc, 2)
    |-> capture_pin_oe_n == $past(hwdata[1], 2))
    else $error("pin direction does not follow its register");
  pin_init_a: assert property ($past(wr_ctrl && hwdata[3:1] == 3'b100, 2)
    |-> capture_pin_out == $past(hwdata[0], 2))
    else $error("compare pin not initialised by mode");
  can_capture_a: assert property (mode_q == 4'h3 && $rose(can_rx_event)
    |-> ##[1:3] unit_event_flag)
    else $error("no event after a received message");
endmodule // ccu_capture_unit_checker

bind ccu_capture_unit ccu_capture_unit_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .capture_pin_in(capture_pin_in),
  .can_rx_event(can_rx_event), .capture_pin_out(capture_pin_out),
  .capture_pin_oe_n(capture_pin_oe_n), .adc_start(adc_start),
  .unit_event_flag(unit_event_flag), .timer_b_overflow_flag(timer_b_overflow_flag));
`default_nettype wire

// file: ccu_event_source.sv
// far side model: the capture pin driver and the message receiver
// assumes the bench calls its tasks; levels change just after hclk edges
`timescale 1ns/1ps
`default_nettype none

module ccu_event_source (
  input  wire logic hclk,
  output var logic  pin_level,
  output var logic  can_rx
);
  initial
  begin
    pin_level = 1'b0;
    can_rx    = 1'b0;
  end
  // gap sets how long each level stands; the bench calls it with a gap of 3 throughout
  task automatic pulses(input int n, input int gap);
    repeat (n)
    begin
      @(posedge hclk) pin_level <= 1'b1;
      repeat (gap) @(posedge hclk);
      pin_level <= 1'b0;
      repeat (gap) @(posedge hclk);
    end
  endtask
  // one received message is one rising edge, held a few cycles
  task automatic message();
    @(posedge hclk) can_rx <= 1'b1;
    repeat (3) @(posedge hclk);
    can_rx <= 1'b0;
  endtask
endmodule // ccu_event_source
`default_nettype wire

// file: ccu_capture_unit_tb_top.sv
// self-checking bench of the capture/compare unit
// assumes ccu_event_source stands for the pin driver and receiver
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"

`define CHK(nm, e, g) \
  comparisons++; \
  if ((g) !== (e)) \
  begin \
    errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end

module ccu_capture_unit_tb_top;
  import ccu_pkg::*;
  // ============================================================
  // signals and tables
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  ccu_word_t   haddr;
  ccu_word_t   hwdata;
  ccu_word_t   hrdata;
  ccu_word_t   rd;
  logic [31:0] seed;
  logic        hreadyout;
  logic        hresp;
  logic        pin_out;
  logic        pin_oe_n;
  logic        adc_start;
  logic        ev_flag;
  logic        ovf_flag;
  logic        src_pin;
  logic        can_rx;
  logic        p0;
  int          errors;
  int          comparisons;
  int          k;
  logic [7:0]  rst_off [4] = '{8'h00, 8'h18, 8'h1C, 8'h20};
  logic [31:0] rst_exp [4] = '{32'h0, 32'h0, 32'h2, 32'h0};
  logic [3:0]  cap_m [4]   = '{4'h4, 4'h5, 4'h6, 4'h7};
  int          cap_n [4]   = '{1, 1, 4, 16};
  logic [3:0]  mid_m [3]   = '{4'h7, 4'h0, 4'hA};
  logic        sw_exp [3]  = '{1'b1, 1'b0, 1'b0};
  logic [3:0]  cmp_m [4]   = '{4'h2, 4'h8, 4'h9, 4'hA};
  // the pin is the design's drive while it is an output
  wire         pin_w = pin_oe_n ? src_pin : pin_out;

  ccu_capture_unit DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capture_pin_in(pin_w),
    .can_rx_event(can_rx), .capture_pin_out(pin_out), .capture_pin_oe_n(pin_oe_n),
    .adc_start(adc_start), .unit_event_flag(ev_flag), .timer_b_overflow_flag(ovf_flag));
  ccu_event_source src (.hclk(hclk), .pin_level(src_pin), .can_rx(can_rx));

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  // ============================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_pin(input logic [3:0] m, input logic p);
    case (m)
      4'h2: exp_pin = !p;
      4'h8: exp_pin = 1'b1;
      4'h9: exp_pin = 1'b0;
      default: exp_pin = p;
    endcase
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wait_sig(input logic adc);
    k = 1;
    @(posedge hclk);
    while ((adc ? adc_start : ev_flag) !== 1'b1 && k < 600)
    begin
      @(posedge hclk);
      k++;
    end
  endtask
  task automatic cap_run(input logic [3:0] m, input int n);
    xfer(1, `CCU_OFF_CTRL, 32'h0);
    xfer(1, `CCU_OFF_CTRL, {28'h0, m});
    seed = lfsr(seed);
    xfer(1, `CCU_OFF_TB_CNT, {16'h0, seed[15:0]});
    xfer(1, `CCU_OFF_STATUS, 32'h1);
    src.pulses(n - 1, 3);
    repeat (10) @(posedge hclk);
    `CHK("early event", 1'b0, ev_flag)
    src.pulses(1, 3);
    repeat (10) @(posedge hclk);
    `CHK("capture event", 1'b1, ev_flag)
    xfer(0, `CCU_OFF_VAL_LO, 32'h0);
    `CHK("value low", seed[7:0], rd[7:0])
    xfer(0, `CCU_OFF_VAL_HI, 32'h0);
    `CHK("value high", seed[15:8], rd[7:0])
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ============================================================
  // watchdog, sized well above the thousand-odd cycles the tests take
  initial
  begin
    repeat (40000) @(posedge hclk);
    errors++;
    $display("watchdog expired");
    wrap_up();
  end

  // ============================================================
  // tests
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 32'hBF76A9E4;
    errors = 0;
    comparisons = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_off[i])
    begin
      xfer(0, rst_off[i], 32'h0);
      `CHK("reset value", rst_exp[i], rd)
    end
    seed = lfsr(seed);
    xfer(1, `CCU_OFF_CTRL, seed);
    xfer(0, `CCU_OFF_CTRL, 32'h0);
    `CHK("control", {26'h0, seed[5:0]}, rd)
    $display("test done: reset and control");
    xfer(1, `CCU_OFF_TB_CTRL, 32'h40);
    foreach (cap_m[i])
      cap_run(cap_m[i], cap_n[i]);
    xfer(1, `CCU_OFF_TB_CNT, 32'h0F0F);
    xfer(1, `CCU_OFF_CTRL, 32'h5);
    src.pulses(1, 3);
    cap_run(4'h5, 1);
    $display("test done: pin captures");
    foreach (mid_m[i])
    begin
      xfer(1, `CCU_OFF_CTRL, 32'h0);
      xfer(1, `CCU_OFF_CTRL, 32'h7);
      src.pulses(3, 3);
      xfer(1, `CCU_OFF_CTRL, {28'h0, mid_m[i]});
      xfer(1, `CCU_OFF_CTRL, 32'h6);
      xfer(1, `CCU_OFF_STATUS, 32'h1);
      src.pulses(1, 3);
      repeat (10) @(posedge hclk);
      `CHK("prescaler kept", sw_exp[i], ev_flag)
    end
    $display("test done: prescaler");
    xfer(1, `CCU_OFF_TB_CTRL, 32'h0);
    xfer(1, `CCU_OFF_MISC, 32'h3);
    xfer(1, `CCU_OFF_CTRL, 32'h3);
    seed = lfsr(seed);
    xfer(1, `CCU_OFF_TA_CNT, {16'h0, seed[15:0]});
    xfer(1, `CCU_OFF_STATUS, 32'h1);
    src.pulses(1, 3);
    repeat (10) @(posedge hclk);
    `CHK("pin ignored", 1'b0, ev_flag)
    src.message();
    repeat (4) @(posedge hclk);
    `CHK("message event", 1'b1, ev_flag)
    xfer(0, `CCU_OFF_VAL_LO, 32'h0);
    `CHK("timer a low", seed[7:0], rd[7:0])
    xfer(1, `CCU_OFF_CTRL, 32'h5);
    xfer(1, `CCU_OFF_STATUS, 32'h1);
    src.pulses(1, 3);
    repeat (10) @(posedge hclk);
    `CHK("select ignores pin", 1'b0, ev_flag)
    $display("test done: message capture");
    xfer(1, `CCU_OFF_MISC, 32'h0);
    xfer(1, `CCU_OFF_CTRL, 32'h5);
    xfer(1, `CCU_OFF_STATUS, 32'h1);
    xfer(1, `CCU_OFF_MISC, 32'h4);
    repeat (10) @(posedge hclk);
    `CHK("port write event", 1'b1, ev_flag)
    xfer(1, `CCU_OFF_MISC, 32'h0);
    $display("test done: port write");
    foreach (cmp_m[i])
    begin
      xfer(1, `CCU_OFF_TB_CTRL, 32'h40);
      xfer(1, `CCU_OFF_TB_CNT, 32'h0);
      seed = lfsr(seed);
      xfer(1, `CCU_OFF_VAL_LO, {27'h0, seed[4:0]} + 32'h10);
      xfer(1, `CCU_OFF_VAL_HI, 32'h0);
      xfer(1, `CCU_OFF_CTRL, {28'h0, cmp_m[i]});
      xfer(1, `CCU_OFF_STATUS, 32'h1);
      p0 = pin_out;
      xfer(1, `CCU_OFF_TB_CTRL, 32'h41);
      wait_sig(1'b0);
      @(posedge hclk);
      `CHK("match event", 1'b1, ev_flag)
      `CHK("pin action", exp_pin(cmp_m[i], p0), pin_out)
    end
    $display("test done: compare");
    xfer(1, `CCU_OFF_TB_CTRL, 32'h40);
    xfer(1, `CCU_OFF_CTRL, 32'h0);
    xfer(1, `CCU_OFF_MISC, 32'h8);
    seed = lfsr(seed);
    xfer(1, `CCU_OFF_VAL_LO, {26'h1, seed[5:0]});
    xfer(1, `CCU_OFF_TB_CNT, 32'h0);
    xfer(1, `CCU_OFF_CTRL, 32'hB);
    xfer(1, `CCU_OFF_STATUS, 32'h3);
    xfer(1, `CCU_OFF_TB_CTRL, 32'h41);
    wait_sig(1'b1);
    wait_sig(1'b1);
    `CHK("trigger period", 32'h41 + seed[5:0], k)
    `CHK("trigger event", 1'b1, ev_flag)
    `CHK("no overflow", 1'b0, ovf_flag)
    xfer(0, `CCU_OFF_TB_CNT, 32'h0);
    `CHK("count within period", 1'b1, rd[15:0] <= {10'h1, seed[5:0]})
    xfer(1, `CCU_OFF_VAL_LO, 32'hFF);
    xfer(1, `CCU_OFF_VAL_HI, 32'hFF);
    xfer(1, `CCU_OFF_TB_CNT, 32'hFFF0);
    xfer(1, `CCU_OFF_STATUS, 32'h3);
    repeat (30) @(posedge hclk);
    `CHK("trigger at wrap", 1'b0, ovf_flag)
    $display("test done: special trigger");
    xfer(1, `CCU_OFF_CTRL, 32'h0);
    xfer(1, `CCU_OFF_TB_CTRL, 32'h40);
    xfer(1, `CCU_OFF_TB_CNT, 32'hFFF0);
    xfer(1, `CCU_OFF_STATUS, 32'h3);
    xfer(1, `CCU_OFF_TB_CTRL, 32'h41);
    repeat (30) @(posedge hclk);
    `CHK("overflow set", 1'b1, ovf_flag)
    xfer(1, `CCU_OFF_TB_CTRL, 32'h40);
    xfer(1, `CCU_OFF_STATUS, 32'h2);
    @(posedge hclk);
    `CHK("overflow cleared", 1'b0, ovf_flag)
    $display("test done: overflow");
    wrap_up();
  end
endmodule // ccu_capture_unit_tb_top
`default_nettype wire
